// ---- hw/phy_ctrl_pkg.sv ----
/*
 * Constants, field layout and carrier type for the basic control register
 * of a 10/100 transceiver. Assumes a 100 MHz device clock.
 */
package phy_ctrl_pkg;

    // Register map, reached as whole 16-bit words.
    localparam logic [4:0] BASIC_PHY_CONTROL_OFFSET = 5'h00;
    localparam logic [15:0] BASIC_PHY_CONTROL_RESET = 16'h3000;

    // Field positions.
    localparam int SOFT_RESET_POS = 15;
    localparam int LOOPBACK_POS = 14;
    localparam int SPEED_LOW_POS = 13;
    localparam int AUTONEG_EN_POS = 12;
    localparam int POWER_DOWN_POS = 11;
    localparam int ISOLATE_POS = 10;
    localparam int AUTONEG_RESTART_POS = 9;
    localparam int DUPLEX_POS = 8;
    localparam int COLLISION_TEST_POS = 7;

    // Timing: the soft reset must be over within this time.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RESET_TIME_US = 25;
    localparam int SOFT_RESET_CYCLES =
        (SOFT_RESET_TIME_US * 1000) / CLK_PERIOD_NS;

    typedef struct packed {
        logic loopback_enable;
        logic speed_select_low;
        logic autoneg_enable;
        logic power_down_bit;
        logic isolate;
        logic duplex_select;
        logic collision_test;
    } ctrl_s;

    // Read-only high speed bit and reserved bits always read zero.
    function automatic logic [15:0] ctrl_word(input ctrl_s c,
                                              input logic rst,
                                              input logic autoneg_restart);
        logic [15:0] w;
        w = 16'h0000;
        w[SOFT_RESET_POS] = rst;
        w[LOOPBACK_POS] = c.loopback_enable;
        w[SPEED_LOW_POS] = c.speed_select_low;
        w[AUTONEG_EN_POS] = c.autoneg_enable;
        w[POWER_DOWN_POS] = c.power_down_bit;
        w[ISOLATE_POS] = c.isolate;
        w[AUTONEG_RESTART_POS] = autoneg_restart;
        w[DUPLEX_POS] = c.duplex_select;
        w[COLLISION_TEST_POS] = c.collision_test;
        return w;
    endfunction : ctrl_word

    function automatic ctrl_s ctrl_fields(input logic [15:0] w);
        ctrl_s c;
        c.loopback_enable = w[LOOPBACK_POS];
        c.speed_select_low = w[SPEED_LOW_POS];
        c.autoneg_enable = w[AUTONEG_EN_POS];
        c.power_down_bit = w[POWER_DOWN_POS];
        c.isolate = w[ISOLATE_POS];
        c.duplex_select = w[DUPLEX_POS];
        c.collision_test = w[COLLISION_TEST_POS];
        return c;
    endfunction : ctrl_fields

endpackage : phy_ctrl_pkg

// ---- hw/soft_reset_timer.sv ----
/*
 * Counts out the soft reset interval after a start strobe.
 * Assumes a synchronous, already released active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module soft_reset_timer #(
    parameter int CYCLES = phy_ctrl_pkg::SOFT_RESET_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);
    import phy_ctrl_pkg::*;

    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (busy_q) begin
            if (cnt_q == LAST) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + W'(1);
            end
        end else if (start) begin
            busy_d = 1'b1;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
endmodule : soft_reset_timer
`default_nettype wire

// ---- hw/phy_basic_control_register.sv ----
/*
 * Basic control register of a 10/100 transceiver and the control outputs
 * it steers. Assumes word-wide management accesses synchronous to clk and a
 * datapath that owns the line and MII pins and honours the enables here.
 */
// Notes on behaviour
// - Soft reset bit resets port, resamples straps.
// - Soft reset ends within 25us, reads one.
// - Loopback disables line driver, returns transmit data.
// - Speed from low bit unless negotiating.
// - Negotiation enable loaded from strap at reset.
// - Power down is bit OR pin.
// - Power down floats line, LEDs, isolates MII.
// - Isolate ignores transmit inputs, floats MII outputs.
// - Restart bit starts negotiation, then self clears.
// - Duplex bit sets duplex without negotiation.
// - Collision test echoes transmit enable on collision.
// - High speed bit always reads zero.
// - Register resets to 3000 hex.
// - Self-clearing bits give one-cycle hardware strobe.
// - Registers addressed as whole 16-bit words.
`timescale 1ns/10ps
`default_nettype none
module phy_basic_control_register (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Management word access
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Straps and pins
    input wire logic autoneg_strap_pin,
    input wire logic power_down_pin,
    // Negotiation engine
    input wire logic an_started,
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    output logic an_restart_strobe,
    output logic autoneg_on,
    // Port control
    output logic port_reset,
    output logic soft_reset_strobe,
    output logic speed_100,
    output logic full_duplex,
    output logic power_down,
    output logic line_tx_oe,
    output logic led_oe,
    output logic mii_oe,
    // MII transmit side from the MAC, toward the datapath
    input wire logic [3:0] mii_txd,
    input wire logic mii_tx_en,
    input wire logic mii_tx_er,
    output logic [3:0] dp_txd,
    output logic dp_tx_en,
    output logic dp_tx_er,
    // MII receive side from the datapath, toward the MAC
    input wire logic [3:0] dp_rxd,
    input wire logic dp_rx_dv,
    input wire logic dp_col,
    output logic [3:0] mii_rxd,
    output logic mii_rx_dv,
    output logic mii_col
);
    import phy_ctrl_pkg::*;

    logic [1:0] rsync_q;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_n = rsync_q[1];

    localparam ctrl_s CTRL_RESET = ctrl_fields(BASIC_PHY_CONTROL_RESET);

    ctrl_s ctrl_q, ctrl_d;
    logic ran_q, ran_d;
    logic strap_q, strap_d;
    logic srst_go, an_go, sr_busy, sr_done, hit_wr;

    soft_reset_timer #(.CYCLES(SOFT_RESET_CYCLES)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(srst_go),
        .busy(sr_busy),
        .done(sr_done)
    );

    assign hit_wr = reg_wr && (reg_addr == BASIC_PHY_CONTROL_OFFSET);

    always_comb begin
        ctrl_d = ctrl_q;
        ran_d = ran_q && !an_started;
        strap_d = 1'b0;
        srst_go = 1'b0;
        an_go = 1'b0;
        if (sr_busy) begin
            ctrl_d = CTRL_RESET;
            ran_d = 1'b0;
            strap_d = sr_done;
        end else if (sr_done) begin
            strap_d = 1'b1;
        end else if (hit_wr) begin
            ctrl_d = ctrl_fields(reg_wdata);
            srst_go = reg_wdata[SOFT_RESET_POS];
            if (reg_wdata[AUTONEG_RESTART_POS] &&
                reg_wdata[AUTONEG_EN_POS] && !srst_go) begin
                ran_d = 1'b1;
                an_go = 1'b1;
            end
            // The port must not run one cycle on the written fields.
            if (srst_go) begin
                ctrl_d = CTRL_RESET;
            end
        end
        // The strap is latched on reset, so it wins over a write.
        // strap load.
        if (strap_q) begin
            ctrl_d.autoneg_enable = autoneg_strap_pin;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            ran_q <= 1'b0;
            strap_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            ran_q <= ran_d;
            strap_q <= strap_d;
        end
    end

    logic [15:0] rdata_d;
    logic busy_bit;
    logic pd_d, iso_d;
    logic [3:0] rxd_d;
    logic rx_dv_d, col_d;

    assign busy_bit = sr_busy || srst_go;
    assign pd_d = ctrl_q.power_down_bit || power_down_pin;
    assign iso_d = ctrl_q.isolate || pd_d;

    always_comb begin
        rdata_d = reg_rdata;
        if (reg_rd) begin
            rdata_d = (reg_addr == BASIC_PHY_CONTROL_OFFSET) ?
                      ctrl_word(ctrl_q, busy_bit, ran_q) : 16'h0000;
        end
        rxd_d = ctrl_q.loopback_enable ? mii_txd : dp_rxd;
        rx_dv_d = ctrl_q.loopback_enable ? mii_tx_en : dp_rx_dv;
        col_d = dp_col || (ctrl_q.collision_test && mii_tx_en);
        if (iso_d) begin
            rxd_d = 4'h0;
            rx_dv_d = 1'b0;
            col_d = 1'b0;
        end
    end

    // Every output is a flip-flop so the MAC never sees decode glitches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            an_restart_strobe <= 1'b0;
            autoneg_on <= 1'b1;
            port_reset <= 1'b0;
            soft_reset_strobe <= 1'b0;
            speed_100 <= 1'b1;
            full_duplex <= 1'b0;
            power_down <= 1'b0;
            line_tx_oe <= 1'b0;
            led_oe <= 1'b0;
            mii_oe <= 1'b0;
            dp_txd <= 4'h0;
            dp_tx_en <= 1'b0;
            dp_tx_er <= 1'b0;
            mii_rxd <= 4'h0;
            mii_rx_dv <= 1'b0;
            mii_col <= 1'b0;
        end else begin
            reg_rdata <= rdata_d;
            an_restart_strobe <= an_go;
            soft_reset_strobe <= srst_go;
            port_reset <= sr_busy;
            autoneg_on <= ctrl_q.autoneg_enable;
            speed_100 <= ctrl_q.autoneg_enable ? an_speed_100 :
                         ctrl_q.speed_select_low;
            full_duplex <= ctrl_q.autoneg_enable ? an_full_duplex :
                           ctrl_q.duplex_select;
            power_down <= pd_d;
            line_tx_oe <= !pd_d && !ctrl_q.loopback_enable;
            led_oe <= !pd_d;
            mii_oe <= !iso_d;
            dp_txd <= iso_d ? 4'h0 : mii_txd;
            dp_tx_en <= !iso_d && mii_tx_en;
            dp_tx_er <= !iso_d && mii_tx_er;
            mii_rxd <= rxd_d;
            mii_rx_dv <= rx_dv_d;
            mii_col <= col_d;
        end
    end

    // Checking helpers.
    logic [15:0] busy_len_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_len_q <= 16'h0000;
        end else begin
            busy_len_q <= sr_busy ? busy_len_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SRST_START: assert property (
        srst_go |=> sr_busy ##1 port_reset)
        else $error("soft reset did not start");
    AST_SRST_BOUND: assert property (
        busy_len_q <= 16'(SOFT_RESET_CYCLES))
        else $error("soft reset too long");
    AST_SRST_READ: assert property (
        reg_rd && reg_addr == BASIC_PHY_CONTROL_OFFSET && sr_busy
        |=> reg_rdata[SOFT_RESET_POS])
        else $error("busy soft reset read as zero");
    AST_LOOP: assert property (
        ctrl_q.loopback_enable && !iso_d
        |=> mii_rxd == $past(mii_txd) && !line_tx_oe)
        else $error("loopback path wrong");
    AST_SPEED: assert property (
        !ctrl_q.autoneg_enable
        |=> speed_100 == $past(ctrl_q.speed_select_low))
        else $error("manual speed wrong");
    AST_STRAP: assert property (
        strap_q && !sr_busy
        |=> ctrl_q.autoneg_enable == $past(autoneg_strap_pin))
        else $error("strap not loaded");
    AST_PD_OR: assert property (power_down_pin |=> power_down)
        else $error("pin did not power down");
    AST_PD_FLOAT: assert property (
        power_down |-> !line_tx_oe && !led_oe && !mii_oe)
        else $error("outputs driven in power down");
    AST_ISO: assert property (
        ctrl_q.isolate && mii_tx_en |=> !mii_oe && !dp_tx_en)
        else $error("isolate leak");
    AST_RAN: assert property (
        an_go |=> an_restart_strobe ##1 !an_restart_strobe)
        else $error("restart strobe wrong");
    AST_DUPLEX_SELECT: assert property (
        !ctrl_q.autoneg_enable
        |=> full_duplex == $past(ctrl_q.duplex_select))
        else $error("manual duplex wrong");
    AST_COL: assert property (
        ctrl_q.collision_test && mii_tx_en && !iso_d |=> mii_col)
        else $error("collision test silent");
    AST_RO: assert property (reg_rdata[6:0] == 7'h00)
        else $error("read-only bits nonzero");
    AST_DEFAULT: assert property (
        sr_done |=> ctrl_q.speed_select_low && !ctrl_q.loopback_enable
        && !ctrl_q.power_down_bit)
        else $error("soft reset default wrong");

    COV_SRST: cover property (srst_go ##1 sr_busy);
    COV_LOOP: cover property (ctrl_q.loopback_enable && mii_tx_en);
    COV_RAN: cover property (an_go ##[1:100] an_started);
endmodule : phy_basic_control_register
`default_nettype wire

// ---- test/phy_far_side_model.sv ----
/*
 * Far side model: negotiation engine and receive datapath.
 * Assumes the control block's clock and its registered strobes.
 */
`timescale 1ns/10ps
`default_nettype none
module phy_far_side_model (
    // Clock and pace
    input wire logic clk,
    input wire logic slow,
    // Negotiation engine
    input wire logic an_restart_strobe,
    output logic an_started,
    // Receive datapath
    output logic [3:0] dp_rxd,
    output logic dp_rx_dv,
    output logic dp_col
);
    logic [7:0] wait_q = 8'h00;
    logic started_q = 1'b0;
    logic [3:0] rxd_q = 4'h5;
    logic dv_q = 1'b0;
    always @(posedge clk) begin
        started_q <= (wait_q == 8'h01);
        if (an_restart_strobe)
            wait_q <= slow ? 8'h40 : 8'h02;
        else if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
    end
    // Receive lines change every cycle, so data one cycle stale never matches.
    always @(posedge clk) begin
        rxd_q <= ~rxd_q + 4'h3;
        dv_q <= ~dv_q;
    end
    // No collisions are seen on the wire in this model.
    assign an_started = started_q;
    assign dp_rxd = rxd_q;
    assign dp_rx_dv = dv_q;
    assign dp_col = 1'b0;
endmodule : phy_far_side_model
`default_nettype wire

// ---- test/phy_basic_control_register_bench.sv ----
/*
 * Self-checking bench for the basic control register.
 * Assumes the far side model file and the design package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module phy_basic_control_register_bench;
    import phy_ctrl_pkg::*;
    logic clk, reset_n, reg_wr, reg_rd, autoneg_strap_pin, power_down_pin;
    logic an_started, an_speed_100, an_full_duplex, an_restart_strobe;
    logic autoneg_on, port_reset, soft_reset_strobe, speed_100, full_duplex;
    logic power_down, line_tx_oe, led_oe, mii_oe, mii_tx_en, mii_tx_er;
    logic dp_tx_en, dp_tx_er, dp_rx_dv, dp_col, mii_rx_dv, mii_col, slow;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [3:0] mii_txd, dp_txd, dp_rxd, mii_rxd, rxd_seen;
    logic [15:0] exp_q[$];
    logic rd_d, rd_d2, dv_seen;
    int mismatches, n_checks, n_rst, n_ran, seed, k;

    phy_basic_control_register u_phy_basic_control_register (
        .clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .autoneg_strap_pin, .power_down_pin, .an_started, .an_speed_100,
        .an_full_duplex, .an_restart_strobe, .autoneg_on, .port_reset,
        .soft_reset_strobe, .speed_100, .full_duplex, .power_down,
        .line_tx_oe, .led_oe, .mii_oe, .mii_txd, .mii_tx_en, .mii_tx_er,
        .dp_txd, .dp_tx_en, .dp_tx_er, .dp_rxd, .dp_rx_dv, .dp_col,
        .mii_rxd, .mii_rx_dv, .mii_col);
    phy_far_side_model u_phy_far_side_model (
        .clk, .slow, .an_restart_strobe, .an_started, .dp_rxd, .dp_rx_dv,
        .dp_col);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic cmp(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic chk(input string what, input logic e, input logic g);
        cmp(what, {15'h0000, e}, {15'h0000, g});
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : wr

    // Reads are spaced two cycles apart, so one slot of latency is safe.
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr = a;
        exp_q.push_back(e);
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(1);
    endtask : rd

    always @(posedge clk) begin
        rd_d <= reg_rd;
        rd_d2 <= rd_d;
        rxd_seen <= dp_rxd;
        dv_seen <= dp_rx_dv;
        n_rst <= n_rst + int'(soft_reset_strobe);
        n_ran <= n_ran + int'(an_restart_strobe);
    end
    always @(negedge clk)
        if (rd_d2 === 1'b1 && exp_q.size() > 0)
            cmp("reg_rdata", exp_q.pop_front(), reg_rdata);

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        {reset_n, reg_wr, reg_rd, power_down_pin, mii_tx_en, mii_tx_er} = 0;
        {an_speed_100, an_full_duplex, slow} = 0;
        {reg_addr, reg_wdata, mii_txd} = 0;
        autoneg_strap_pin = 1'b1;
        {mismatches, n_checks} = 0;
        seed = 32'ha2a9;
        tick(3);
        reset_n = 1'b1;
        tick(4);
        rd(5'h00, 16'h3000);
        chk("autoneg_on", 1'b1, autoneg_on);
        rd(5'h05, 16'h0000);
        wr(5'h05, 16'hFFFF);
        rd(5'h00, 16'h3000);
        wr(5'h00, 16'h007F);
        rd(5'h00, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(5'h00, {2'b00, i[1], 4'h0, i[0], 8'h40});
            tick(2);
            chk("speed_100", i[1], speed_100);
            chk("full_duplex", i[0], full_duplex);
        end
        for (int i = 0; i < 3; i++) begin
            {an_speed_100, an_full_duplex} = 2'($random(seed));
            wr(5'h00, {2'b00, ~an_speed_100, 4'h8, ~an_full_duplex, 8'h00});
            tick(2);
            chk("speed_100", an_speed_100, speed_100);
            chk("full_duplex", an_full_duplex, full_duplex);
        end
        // Loopback only with negotiation off, as the station must.
        wr(5'h00, 16'h4080);
        for (int i = 0; i < 4; i++) begin
            {mii_txd, mii_tx_en, mii_tx_er} = 6'($random(seed));
            tick(2);
            cmp("mii_rxd", {12'h000, mii_txd}, {12'h000, mii_rxd});
            chk("mii_rx_dv", mii_tx_en, mii_rx_dv);
            chk("mii_col", mii_tx_en, mii_col);
        end
        chk("line_tx_oe", 1'b0, line_tx_oe);
        {mii_txd, mii_tx_en, mii_tx_er} = 6'h3F;
        wr(5'h00, 16'h0480);
        tick(2);
        chk("dp_tx_en", 1'b0, dp_tx_en);
        chk("dp_tx_er", 1'b0, dp_tx_er);
        chk("mii_oe", 1'b0, mii_oe);
        chk("mii_col", 1'b0, mii_col);
        cmp("mii_rxd", 16'h0000, {12'h000, mii_rxd});
        rd(5'h00, 16'h0480);
        wr(5'h00, 16'h0000);
        tick(2);
        cmp("dp_txd", {12'h000, mii_txd}, {12'h000, dp_txd});
        chk("dp_tx_er", 1'b1, dp_tx_er);
        cmp("mii_rxd", {12'h000, rxd_seen}, {12'h000, mii_rxd});
        chk("mii_rx_dv", dv_seen, mii_rx_dv);
        for (int i = 0; i < 4; i++) begin
            power_down_pin = i[0];
            wr(5'h00, {4'h0, i[1], 11'h000});
            tick(2);
            chk("power_down", i[0] | i[1], power_down);
            chk("led_oe", ~(i[0] | i[1]), led_oe);
            chk("line_tx_oe", ~(i[0] | i[1]), line_tx_oe);
            chk("mii_oe", ~(i[0] | i[1]), mii_oe);
        end
        power_down_pin = 1'b0;
        slow = 1'b1;
        wr(5'h00, 16'h1200);
        rd(5'h00, 16'h1200);
        tick(80);
        rd(5'h00, 16'h1000);
        chk("restart_once", 1'b1, n_ran == 1);
        slow = 1'b0;
        wr(5'h00, 16'h0200);
        tick(5);
        chk("restart_off", 1'b1, n_ran == 1);
        wr(5'h00, 16'h1200);
        tick(10);
        chk("restart_fast", 1'b1, n_ran == 2);
        rd(5'h00, 16'h1000);
        autoneg_strap_pin = 1'b0;
        wr(5'h00, 16'h0100);
        wr(5'h00, 16'h8000);
        rd(5'h00, 16'hB000);
        wr(5'h00, 16'h0100);
        chk("port_reset", 1'b1, port_reset);
        for (k = 0; k < 2600 && port_reset === 1'b1; k++)
            tick(1);
        chk("reset_time", 1'b1, k < SOFT_RESET_CYCLES);
        // The strap is taken one cycle after port reset falls.
        tick(1);
        rd(5'h00, 16'h2000);
        chk("full_duplex", 1'b0, full_duplex);
        chk("reset_strobe", 1'b1, n_rst == 1);
        tick(4);
        test_done();
    end
endmodule : phy_basic_control_register_bench
`default_nettype wire
